// ==== logic/cac_alu_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface cac_alu_if;
    logic [31:0] accu;
    logic [31:0] xreg;
    logic [3:0] op;
    logic [31:0] resAccu;
    logic [31:0] resX;
    modport user (output accu, output xreg, output op, input resAccu, input resX);
    modport alu (input accu, input xreg, input op, output resAccu, output resX);
endinterface
`default_nettype wire

// ==== logic/cac_pkg.sv ====
`default_nettype none
package cac_pkg;
    // instruction codes
    localparam logic [7:0] INSTR_CAPTURE = 8'h20;
    localparam logic [7:0] INSTR_CALC = 8'h21;
    localparam logic [7:0] INSTR_TO_AXIS = 8'h22;
    localparam logic [7:0] INSTR_TO_GLOBAL = 8'h23;
    localparam logic [7:0] INSTR_TO_COORD = 8'h27;
    // second register operations
    localparam logic [3:0] OP_ADD = 4'h0;
    localparam logic [3:0] OP_SUB = 4'h1;
    localparam logic [3:0] OP_PRODUCT = 4'h2;
    localparam logic [3:0] OP_DIV = 4'h3;
    localparam logic [3:0] OP_REMAINDER = 4'h4;
    localparam logic [3:0] OP_AND = 4'h5;
    localparam logic [3:0] OP_OR = 4'h6;
    localparam logic [3:0] OP_XOR = 4'h7;
    localparam logic [3:0] OP_NOT = 4'h8;
    localparam logic [3:0] OP_LOAD = 4'h9;
    localparam logic [3:0] OP_SWAP = 4'ha;
    // reply status codes
    localparam logic [7:0] ST_OK = 8'h64;
    localparam logic [7:0] ST_CHKSUM = 8'h01;
    localparam logic [7:0] ST_BADCMD = 8'h02;
    localparam logic [7:0] ST_BADTYPE = 8'h03;
    localparam logic [7:0] ST_BADVAL = 8'h04;
    // argument limits
    localparam logic [7:0] MAX_COORD = 8'h14;
    localparam logic [7:0] MAX_AXIS = 8'h05;
    localparam logic [7:0] MAX_OP = 8'h0a;
    localparam logic [7:0] BANK_A = 8'h00;
    localparam logic [7:0] BANK_B = 8'h02;
    localparam logic [7:0] BANK_C = 8'h03;
    // frame and store geometry
    localparam logic [3:0] FRAME_LAST = 4'h8;
    localparam logic [7:0] DEF_MODULE_ADDR = 8'h01;
    localparam int NUM_AXES = 6;
    localparam int NUM_COORDS = 21;

    typedef enum logic {CAC_IDLE = 1'b0, CAC_EXEC = 1'b1} cac_state_t;

    typedef struct packed {
        cac_state_t state;
        logic [3:0] cnt;
        logic [7:0] sum;
        logic [63:0] frame;
        logic chkOk;
        logic direct;
        logic [31:0] accu;
        logic [31:0] xreg;
        logic replyValid;
        logic [7:0] replyStatus;
        logic [7:0] replyInstr;
        logic [31:0] replyValue;
        logic apWr;
        logic gpWr;
        logic [7:0] prmIndex;
        logic [7:0] prmTarget;
        logic [31:0] prmData;
        logic nvWr;
        logic [2:0] nvAxis;
        logic [4:0] nvIdx;
        logic [31:0] nvData;
    } cac_st_t;
endpackage
`default_nettype wire

// ==== logic/cac_top.sv ====
// What this block does
// - code 32 captures axis position into coordinate
// - twenty-one coordinate entries kept per axis
// - persistence setting mirrors coordinates to nonvolatile
// - coordinate zero never leaves volatile store
// - capture replies status 100 with position
// - code 39 stores accumulator into coordinate
// - code 33 combines accumulator with X
// - operations 0..7 add, sub, mul, div, mod, logic
// - 8 invert X, 9 load X, 10 swap
// - code 34 writes accumulator to axis parameter
// - code 35 writes accumulator to global parameter
// - calculation commands accepted in direct mode too
`timescale 1ns/10ps
`default_nettype none
module cac_top #(
    parameter logic [7:0] MODULE_ADDR = cac_pkg::DEF_MODULE_ADDR,
    parameter int NUM_AXES = cac_pkg::NUM_AXES,
    parameter int NUM_COORDS = cac_pkg::NUM_COORDS
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // direct mode frame bytes
    input wire logic rxValid,
    input wire logic [7:0] rxByte,
    output logic rxReady,
    // standalone program commands
    input wire logic progValid,
    input wire logic [7:0] progInstr,
    input wire logic [7:0] progType,
    input wire logic [7:0] progBank,
    input wire logic [31:0] progValue,
    output logic progReady,
    // accumulator load from other commands
    input wire logic accuLoadValid,
    input wire logic [31:0] accuLoadData,
    output logic [31:0] accuValue,
    // motion engine positions and persistence setting
    input wire logic [31:0] axisPos [NUM_AXES],
    input wire logic persistCoord,
    // reply
    output logic replyValid,
    output logic [7:0] replyStatus,
    output logic [7:0] replyInstr,
    output logic [31:0] replyValue,
    // parameter writes
    output logic apWrValid,
    output logic gpWrValid,
    output logic [7:0] paramIndex,
    output logic [7:0] paramTarget,
    output logic [31:0] paramData,
    // nonvolatile mirror and startup restore
    output logic nvWrValid,
    output logic [2:0] nvWrAxis,
    output logic [4:0] nvWrIdx,
    output logic [31:0] nvWrData,
    input wire logic nvRdValid,
    input wire logic [2:0] nvRdAxis,
    input wire logic [4:0] nvRdIdx,
    input wire logic [31:0] nvRdData,
    // coordinate read port
    input wire logic [2:0] coordRdAxis,
    input wire logic [4:0] coordRdIdx,
    output logic [31:0] coordRdData
);
    cac_pkg::cac_st_t st_q;
    cac_pkg::cac_st_t st_d;
    logic [31:0] coordMem [NUM_AXES][NUM_COORDS];
    logic wrEn;
    logic [2:0] wrAxis;
    logic [4:0] wrIdx;
    logic [31:0] wrData;
    logic [31:0] posSel;
    logic frameDone;
    logic restoreOk;
    logic [7:0] fInstr;
    logic [7:0] fType;
    logic [7:0] fBank;
    cac_alu_if aluBus ();

    cac_xalu u_alu (
        .bus(aluBus.alu)
    );

    assign fInstr = st_q.frame[55:48];
    assign fType = st_q.frame[47:40];
    assign fBank = st_q.frame[39:32];
    assign aluBus.accu = st_q.accu;
    assign aluBus.xreg = st_q.xreg;
    assign aluBus.op = fType[3:0];
    assign posSel = (fBank <= cac_pkg::MAX_AXIS) ? axisPos[fBank[2:0]] : 32'h0;
    assign rxReady = (st_q.state == cac_pkg::CAC_IDLE);
    assign progReady = rxReady && !rxValid && (st_q.cnt == 4'h0);
    assign frameDone = rxValid && rxReady && (st_q.cnt == cac_pkg::FRAME_LAST);
    assign restoreOk = nvRdValid && persistCoord && (nvRdIdx != 5'h0)
        && ({3'h0, nvRdIdx} <= cac_pkg::MAX_COORD) && ({5'h0, nvRdAxis} <= cac_pkg::MAX_AXIS);

    always_comb begin
        st_d = st_q;
        st_d.replyValid = 1'b0;
        st_d.apWr = 1'b0;
        st_d.gpWr = 1'b0;
        st_d.nvWr = 1'b0;
        wrEn = 1'b0;
        wrAxis = fBank[2:0];
        wrIdx = fType[4:0];
        wrData = st_q.accu;
        unique case (st_q.state)
            cac_pkg::CAC_IDLE: begin
                if (accuLoadValid) begin
                    st_d.accu = accuLoadData;
                end
                if (rxValid) begin
                    st_d.cnt = st_q.cnt + 4'h1;
                    st_d.sum = st_q.sum + rxByte;
                    st_d.frame = {st_q.frame[55:0], rxByte};
                    if (st_q.cnt == cac_pkg::FRAME_LAST) begin
                        st_d.cnt = 4'h0;
                        st_d.sum = 8'h0;
                        st_d.frame = st_q.frame;
                        st_d.chkOk = (st_q.sum == rxByte);
                        st_d.direct = 1'b1;
                        if (st_q.frame[63:56] == MODULE_ADDR) begin
                            st_d.state = cac_pkg::CAC_EXEC;
                        end
                    end
                end else if (progValid && progReady) begin
                    st_d.frame = {MODULE_ADDR, progInstr, progType, progBank, progValue};
                    st_d.chkOk = 1'b1;
                    st_d.direct = 1'b0;
                    st_d.state = cac_pkg::CAC_EXEC;
                end
            end
            cac_pkg::CAC_EXEC: begin
                st_d.state = cac_pkg::CAC_IDLE;
                st_d.replyValid = st_q.direct;
                st_d.replyInstr = fInstr;
                st_d.replyStatus = cac_pkg::ST_OK;
                st_d.replyValue = 32'h0;
                st_d.prmIndex = fType;
                st_d.prmTarget = fBank;
                st_d.prmData = st_q.accu;
                if (!st_q.chkOk) begin
                    st_d.replyStatus = cac_pkg::ST_CHKSUM;
                end else begin
                    unique case (fInstr)
                        cac_pkg::INSTR_CAPTURE, cac_pkg::INSTR_TO_COORD: begin
                            if (fType > cac_pkg::MAX_COORD || fBank > cac_pkg::MAX_AXIS) begin
                                st_d.replyStatus = cac_pkg::ST_BADVAL;
                            end else begin
                                wrEn = 1'b1;
                                if (fInstr == cac_pkg::INSTR_CAPTURE) begin
                                    wrData = posSel;
                                    st_d.replyValue = posSel;
                                end
                                st_d.nvWr = persistCoord && (fType != 8'h0);
                                st_d.nvAxis = fBank[2:0];
                                st_d.nvIdx = fType[4:0];
                                st_d.nvData = wrData;
                            end
                        end
                        cac_pkg::INSTR_CALC: begin
                            if (fType > cac_pkg::MAX_OP) begin
                                st_d.replyStatus = cac_pkg::ST_BADTYPE;
                            end else begin
                                st_d.accu = aluBus.resAccu;
                                st_d.xreg = aluBus.resX;
                            end
                        end
                        cac_pkg::INSTR_TO_AXIS: begin
                            if (fBank > cac_pkg::MAX_AXIS) begin
                                st_d.replyStatus = cac_pkg::ST_BADVAL;
                            end else begin
                                st_d.apWr = 1'b1;
                            end
                        end
                        cac_pkg::INSTR_TO_GLOBAL: begin
                            if (fBank == cac_pkg::BANK_A || fBank == cac_pkg::BANK_B
                                || fBank == cac_pkg::BANK_C) begin
                                st_d.gpWr = 1'b1;
                            end else begin
                                st_d.replyStatus = cac_pkg::ST_BADVAL;
                            end
                        end
                        default: st_d.replyStatus = cac_pkg::ST_BADCMD;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // coordinate store, command write wins over restore
    always_ff @(posedge clock) begin
        if (wrEn) begin
            coordMem[wrAxis][wrIdx] <= wrData;
        end else if (restoreOk) begin
            coordMem[nvRdAxis][nvRdIdx] <= nvRdData;
        end
        if ({5'h0, coordRdAxis} <= cac_pkg::MAX_AXIS
            && {3'h0, coordRdIdx} <= cac_pkg::MAX_COORD) begin
            coordRdData <= coordMem[coordRdAxis][coordRdIdx];
        end else begin
            coordRdData <= 32'h0;
        end
    end

    assign accuValue = st_q.accu;
    assign replyValid = st_q.replyValid;
    assign replyStatus = st_q.replyStatus;
    assign replyInstr = st_q.replyInstr;
    assign replyValue = st_q.replyValue;
    assign apWrValid = st_q.apWr;
    assign gpWrValid = st_q.gpWr;
    assign paramIndex = st_q.prmIndex;
    assign paramTarget = st_q.prmTarget;
    assign paramData = st_q.prmData;
    assign nvWrValid = st_q.nvWr;
    assign nvWrAxis = st_q.nvAxis;
    assign nvWrIdx = st_q.nvIdx;
    assign nvWrData = st_q.nvData;

    // checks
    logic execOk;
    assign execOk = (st_q.state == cac_pkg::CAC_EXEC) && st_q.chkOk;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_capture_reply: assert property (execOk && fInstr == cac_pkg::INSTR_CAPTURE
        && st_q.direct && wrEn |=> replyValid && replyValue == $past(posSel)
        && replyStatus == cac_pkg::ST_OK) else $error("capture reply wrong");
    a_capture_store: assert property (execOk && fInstr == cac_pkg::INSTR_CAPTURE
        && wrEn |-> wrData == posSel) else $error("capture data wrong");
    a_store_index: assert property (wrEn |-> {3'h0, wrIdx} <= cac_pkg::MAX_COORD
        && {5'h0, wrAxis} <= cac_pkg::MAX_AXIS) else $error("store index out of range");
    a_nv_persist: assert property (nvWrValid |-> $past(persistCoord))
        else $error("mirror write without persistence");
    a_nv_zero: assert property (nvWrValid |-> nvWrIdx != 5'h0)
        else $error("coordinate zero mirrored");
    a_accu_coord: assert property (execOk && fInstr == cac_pkg::INSTR_TO_COORD && wrEn
        |-> wrData == st_q.accu ##1 (nvWrValid == persistCoord || nvWrIdx == 5'h0))
        else $error("accumulator store wrong");
    a_calc_add: assert property (execOk && fInstr == cac_pkg::INSTR_CALC
        && fType == 8'h0 |=> accuValue == $past(st_q.accu) + $past(st_q.xreg))
        else $error("add result wrong");
    a_calc_swap: assert property (execOk && fInstr == cac_pkg::INSTR_CALC
        && fType == 8'h0a |=> accuValue == $past(st_q.xreg) && st_q.xreg == $past(st_q.accu))
        else $error("swap wrong");
    a_dont_care_val: assert property (replyValid && replyStatus == cac_pkg::ST_OK
        && replyInstr != cac_pkg::INSTR_CAPTURE |-> replyValue == 32'h0)
        else $error("reply value not zero");
    a_axis_write: assert property (apWrValid |-> paramTarget <= cac_pkg::MAX_AXIS
        && paramData == $past(st_q.accu)) else $error("axis parameter write wrong");
    a_global_bank: assert property (gpWrValid |-> paramTarget == 8'h0
        || paramTarget == 8'h02 || paramTarget == 8'h03) else $error("bad bank written");
    a_direct_reply: assert property (frameDone && st_q.frame[63:56] == MODULE_ADDR
        |-> ##2 replyValid) else $error("direct frame not answered");
    a_checksum_bad: assert property (frameDone && st_q.sum != rxByte
        && st_q.frame[63:56] == MODULE_ADDR |-> ##2 replyValid
        && replyStatus == cac_pkg::ST_CHKSUM && !apWrValid && !gpWrValid)
        else $error("bad checksum not refused");
    a_frame_busy: assert property (frameDone |=> !rxReady ||
        $past(st_q.frame[63:56]) != MODULE_ADDR) else $error("frame not executed");

    c_capture: cover property (replyValid && replyInstr == cac_pkg::INSTR_CAPTURE);
    c_calc_prog: cover property (execOk && !st_q.direct && fInstr == cac_pkg::INSTR_CALC);
    c_global: cover property (gpWrValid);
    c_chk_err: cover property (replyValid && replyStatus == cac_pkg::ST_CHKSUM);
endmodule // cac_top
`default_nettype wire

// ==== logic/cac_xalu.sv ====
`timescale 1ns/10ps
`default_nettype none
module cac_xalu (
    // operands and results
    cac_alu_if.alu bus
);
    logic signed [31:0] a;
    logic signed [31:0] x;

    always_comb begin
        a = bus.accu;
        x = bus.xreg;
        bus.resAccu = bus.accu;
        bus.resX = bus.xreg;
        unique case (bus.op)
            cac_pkg::OP_ADD: bus.resAccu = a + x;
            cac_pkg::OP_SUB: bus.resAccu = a - x;
            cac_pkg::OP_PRODUCT: bus.resAccu = a * x;
            // division by zero leaves the accumulator unchanged
            cac_pkg::OP_DIV: bus.resAccu = (x == 32'sh0) ? a : a / x;
            cac_pkg::OP_REMAINDER: bus.resAccu = (x == 32'sh0) ? a : a % x;
            cac_pkg::OP_AND: bus.resAccu = a & x;
            cac_pkg::OP_OR: bus.resAccu = a | x;
            cac_pkg::OP_XOR: bus.resAccu = a ^ x;
            cac_pkg::OP_NOT: bus.resX = ~x;
            cac_pkg::OP_LOAD: bus.resX = a;
            cac_pkg::OP_SWAP: begin
                bus.resAccu = x;
                bus.resX = a;
            end
            default: begin
                bus.resAccu = bus.accu;
                bus.resX = bus.xreg;
            end
        endcase
    end
endmodule // cac_xalu
`default_nettype wire

// ==== verif/cac_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module cac_host_model (
    // clock
    input wire logic clock,
    // frame byte stream
    output logic rxValid,
    output logic [7:0] rxByte,
    input wire logic rxReady
);
    initial begin
        rxValid = 1'b0;
        rxByte = 8'h00;
    end

    // one whole frame, each byte held until taken
    task automatic send(input logic [7:0] ad, input logic [7:0] ins, input logic [7:0] ty,
            input logic [7:0] bk, input logic [31:0] v, input logic [7:0] se);
        logic [7:0] f [9];
        f = '{ad, ins, ty, bk, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
        f[8] = f[0] + f[1] + f[2] + f[3] + f[4] + f[5] + f[6] + f[7] + se;
        @(posedge clock);
        for (int i = 0; i < 9; i++) begin
            rxValid <= 1'b1;
            rxByte <= f[i];
            @(posedge clock);
            while (rxReady !== 1'b1) @(posedge clock);
        end
        rxValid <= 1'b0;
        rxByte <= ~f[8];
    endtask
endmodule // cac_host_model
`default_nettype wire

// ==== verif/tb_coordinate_accu_calc_cmds.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_coordinate_accu_calc_cmds;
    localparam logic [7:0] OK = cac_pkg::ST_OK;
    logic clock = 1'b0;
    logic rst;
    logic rxValid, rxReady, progValid, progReady, accuLoadValid, persistCoord;
    logic [7:0] rxByte, progInstr, progType, progBank, replyStatus, replyInstr;
    logic [31:0] progValue, accuLoadData, accuValue, replyValue;
    logic [31:0] axisPos [6];
    logic replyValid, apWrValid, gpWrValid, nvWrValid, nvRdValid, pAp, pGp, pNv;
    logic [7:0] paramIndex, paramTarget;
    logic [31:0] paramData, nvWrData, nvRdData, coordRdData, accM, xM, a;
    logic [2:0] nvWrAxis, nvRdAxis, coordRdAxis;
    logic [4:0] nvWrIdx, nvRdIdx, coordRdIdx;
    logic [7:0] fAddr = 8'h01;
    logic [7:0] fErr = 8'h00;
    logic [2:0] axT [3] = '{3'h5, 3'h0, 3'h2};
    logic [4:0] ixT [3] = '{5'h14, 5'h00, 5'h01};
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;

    always #5 clock = ~clock;

    cac_top dut (.clock(clock), .rst(rst), .rxValid(rxValid), .rxByte(rxByte),
        .rxReady(rxReady), .progValid(progValid), .progInstr(progInstr), .progType(progType),
        .progBank(progBank), .progValue(progValue), .progReady(progReady),
        .accuLoadValid(accuLoadValid), .accuLoadData(accuLoadData), .accuValue(accuValue),
        .axisPos(axisPos), .persistCoord(persistCoord), .replyValid(replyValid),
        .replyStatus(replyStatus), .replyInstr(replyInstr), .replyValue(replyValue),
        .apWrValid(apWrValid), .gpWrValid(gpWrValid), .paramIndex(paramIndex),
        .paramTarget(paramTarget), .paramData(paramData), .nvWrValid(nvWrValid),
        .nvWrAxis(nvWrAxis), .nvWrIdx(nvWrIdx), .nvWrData(nvWrData), .nvRdValid(nvRdValid),
        .nvRdAxis(nvRdAxis), .nvRdIdx(nvRdIdx), .nvRdData(nvRdData),
        .coordRdAxis(coordRdAxis), .coordRdIdx(coordRdIdx), .coordRdData(coordRdData));
    cac_host_model host (.clock(clock), .rxValid(rxValid), .rxByte(rxByte), .rxReady(rxReady));

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            $display("[ERR] %0t run timed out", $time);
            final_report();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] ev, input string what);
        n_tests++;
        if (got !== ev) begin
            $display("[ERR] %0t %s: got %0h exp %0h", $time, what, got, ev);
            err_count++;
        end
    endtask

    // reference accumulator and second register
    function automatic void calc(input int op);
        logic [31:0] t;
        t = accM;
        case (op)
            0: accM = accM + xM;
            1: accM = accM - xM;
            2: accM = accM * xM;
            3: if (xM != 0) accM = $signed(accM) / $signed(xM);
            4: if (xM != 0) accM = $signed(accM) % $signed(xM);
            5: accM = accM & xM;
            6: accM = accM | xM;
            7: accM = accM ^ xM;
            8: xM = ~xM;
            9: xM = accM;
            default: begin
                accM = xM;
                xM = t;
            end
        endcase
    endfunction

    // frame and reply; status ff means no reply
    task automatic frame(input logic [7:0] ins, input logic [7:0] ty, input logic [7:0] bk,
            input logic [7:0] st, input logic [31:0] rv);
        int n;
        host.send(fAddr, ins, ty, bk, $urandom, fErr);
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (replyValid !== 1'b1 && n < 4);
        pAp = apWrValid;
        pGp = gpWrValid;
        pNv = nvWrValid;
        if (st == 8'hff) begin
            chk(replyValid, 1'b0, "stray reply");
        end else begin
            chk({n, replyStatus, replyInstr}, {32'd1, st, ins}, "reply head");
            if (st == OK) begin
                chk(replyValue, rv, "reply value");
            end
        end
    endtask

    task automatic prog(input logic [7:0] ins, input logic [7:0] ty, input logic [7:0] bk);
        @(posedge clock);
        progValid <= 1'b1;
        progInstr <= ins;
        progType <= ty;
        progBank <= bk;
        progValue <= $urandom;
        @(posedge clock);
        while (progReady !== 1'b1) @(posedge clock);
        progValid <= 1'b0;
        @(posedge clock);
        #1;
        pAp = apWrValid;
    endtask

    task automatic load(input logic [31:0] v);
        @(posedge clock);
        accuLoadValid <= 1'b1;
        accuLoadData <= v;
        @(posedge clock);
        accuLoadValid <= 1'b0;
        #1;
        accM = v;
        chk(accuValue, v, "accu load");
    endtask

    task automatic rd(input logic [2:0] ax, input logic [4:0] ix, input logic [31:0] ev);
        @(posedge clock);
        coordRdAxis <= ax;
        coordRdIdx <= ix;
        repeat (2) @(posedge clock);
        #1;
        chk(coordRdData, ev, "coord read");
    endtask

    initial begin
        a = $urandom(66677);
        rst = 1'b1;
        {progValid, accuLoadValid, nvRdValid, progInstr, progType, progBank} = '0;
        {progValue, accuLoadData, nvRdAxis, nvRdIdx, nvRdData, coordRdAxis, coordRdIdx} = '0;
        persistCoord = 1'b1;
        for (int i = 0; i < 6; i++) begin
            axisPos[i] = $urandom;
        end
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        #1;
        chk({rxReady, replyValid, apWrValid, accuValue}, {3'b100, 32'h0}, "reset");
        for (int k = 0; k <= 10; k++) begin
            load($urandom_range(1, 9999));
            frame(cac_pkg::INSTR_CALC, 8'h09, 8'h00, OK, 32'h0);
            calc(9);
            load($urandom);
            if (k % 2 == 0) begin
                frame(cac_pkg::INSTR_CALC, 8'(k), 8'h00, OK, 32'h0);
            end else begin
                prog(cac_pkg::INSTR_CALC, 8'(k), 8'h00);
            end
            calc(k);
            chk(accuValue, accM, "calc");
            frame(cac_pkg::INSTR_CALC, 8'h0a, 8'h00, OK, 32'h0);
            calc(10);
            chk(accuValue, accM, "swap");
        end
        for (int i = 0; i < 3; i++) begin
            frame(cac_pkg::INSTR_CAPTURE, 8'(ixT[i]), 8'(axT[i]), OK, axisPos[axT[i]]);
            chk(pNv, ixT[i] != 0, "mirror pulse");
            if (ixT[i] != 0) begin
                chk({nvWrAxis, nvWrIdx, nvWrData}, {axT[i], ixT[i], axisPos[axT[i]]}, "mirror");
            end
            rd(axT[i], ixT[i], axisPos[axT[i]]);
        end
        @(posedge clock);
        persistCoord <= 1'b0;
        load($urandom);
        frame(cac_pkg::INSTR_TO_COORD, 8'h07, 8'h03, OK, 32'h0);
        chk(pNv, 1'b0, "no mirror");
        a = accM;
        rd(3'h3, 5'h07, a);
        load($urandom);
        fErr = 8'h01;
        frame(cac_pkg::INSTR_TO_COORD, 8'h07, 8'h03, 8'h01, 32'h0);
        fErr = 8'h00;
        fAddr = 8'h02;
        frame(cac_pkg::INSTR_TO_COORD, 8'h07, 8'h03, 8'hff, 32'h0);
        fAddr = 8'h01;
        rd(3'h3, 5'h07, a);
        frame(cac_pkg::INSTR_CAPTURE, 8'h15, 8'h00, 8'h04, 32'h0);
        frame(8'h24, 8'h00, 8'h00, 8'h02, 32'h0);
        frame(cac_pkg::INSTR_CALC, 8'h0b, 8'h00, 8'h03, 32'h0);
        frame(cac_pkg::INSTR_TO_AXIS, 8'h00, 8'h06, 8'h04, 32'h0);
        chk(pAp, 1'b0, "bad axis");
        frame(cac_pkg::INSTR_TO_AXIS, 8'h04, 8'h05, OK, 32'h0);
        chk({pAp, paramIndex, paramTarget, paramData}, {9'h104, 8'h05, accM}, "axis prm");
        prog(cac_pkg::INSTR_TO_AXIS, 8'h2a, 8'h00);
        chk({pAp, paramIndex, paramTarget, paramData}, {9'h12a, 8'h00, accM}, "prog prm");
        for (int i = 0; i < 4; i++) begin
            load($urandom);
            frame(cac_pkg::INSTR_TO_GLOBAL, 8'h2a, 8'(i), (i == 1) ? 8'h04 : OK, 32'h0);
            chk({pGp, paramTarget, paramData}, {i != 1, 8'(i), accM}, "global prm");
        end
        @(posedge clock);
        persistCoord <= 1'b1;
        nvRdValid <= 1'b1;
        nvRdAxis <= 3'h4;
        nvRdIdx <= 5'h09;
        nvRdData <= a;
        @(posedge clock);
        nvRdValid <= 1'b0;
        rd(3'h4, 5'h09, a);
        final_report();
    end
endmodule // tb_coordinate_accu_calc_cmds
`default_nettype wire
